// ---- src/psm_pkg.sv ----
/*
 * Package for the pin state / power mode controller: power modes,
 * per-pin carriers and wake-up pin classes.
 * Assumes one synchronous clock domain; no register bus.
 */
package psm_pkg;

    localparam int PSM_PINS_DEF    = 16;
    localparam int PSM_MODE_W      = 3;
    // power modes as presented by the power management logic
    typedef enum logic [2:0] {
        PSM_RUN    = 3'b000,
        PSM_HALT   = 3'b001,
        PSM_IDLE   = 3'b010,
        PSM_WATCH  = 3'b011,
        PSM_SWATCH = 3'b100,
        PSM_STOP   = 3'b101
    } psm_mode_t;

    // controller states
    typedef enum logic [1:0] {
        PSM_ST_RESET = 2'b00,
        PSM_ST_RUN   = 2'b01,
        PSM_ST_HOLD  = 2'b10
    } psm_state_t;

    // pin class codes for the wake-up capability map
    localparam logic [1:0] PSM_CLS_NONE = 2'h0;
    localparam logic [1:0] PSM_CLS_EXTI = 2'h1;
    localparam logic [1:0] PSM_CLS_NMI  = 2'h2;
    localparam logic [1:0] PSM_CLS_CANR = 2'h3;

    // drive value of one pin from the port logic
    typedef struct packed {
        logic oe;
        logic out;
    } psm_drive_t;

    localparam logic PSM_FLASH_NORMAL = 1'b0;
    localparam logic PSM_OE_RESET     = 1'b0;
    localparam logic PSM_OUT_RESET    = 1'b0;

endpackage : psm_pkg

// ---- src/psm_hold_reg.sv ----
/*
 * Per-pin hold register: captures the port drive at power save entry.
 * Assumes capture pulses come from the controller in the same domain.
 */
`timescale 1ns/1ps
`default_nettype none
module psm_hold_reg #(
    parameter int PINS = 16
) (
    input  wire logic                  clock,
    input  wire logic                  rstn,
    input  wire logic                  capture,
    input  wire psm_pkg::psm_drive_t [PINS-1:0] drive_in,
    output var  psm_pkg::psm_drive_t [PINS-1:0] held_ff
);
    import psm_pkg::*;

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            always_ff @(posedge clock) begin
                if (!rstn) begin
                    held_ff[g].oe  <= PSM_OE_RESET;
                    held_ff[g].out <= PSM_OUT_RESET;
                end else if (capture) begin
                    held_ff[g] <= drive_in[g];
                end
            end
        end
    endgenerate
endmodule : psm_hold_reg
`default_nettype wire

// ---- src/psm_pin_ctrl.sv ----
/*
 * Pin state controller across reset and power save modes: a small
 * state machine, the per-pin hold register for deep power save, the
 * pad output mux and the gated input path towards the core.
 * Assumes port logic drive/input signals and the power mode are
 * synchronous to clock; pad tristate is resolved outside.
 * Assumes the wake-up class of each pin is fixed by PIN_CLASS and
 * that port logic keeps its drive unchanged across power save.
 */
`timescale 1ns/1ps
`default_nettype none
module psm_pin_ctrl #(
    parameter int PINS = 16,
    parameter logic [2*PINS-1:0] PIN_CLASS = '0
) (
    input  wire logic                           clock,
    input  wire logic                           rstn,
    // mode inputs
    input  wire logic                           flash_mode_select_pin,
    input  wire psm_pkg::psm_mode_t             power_mode,
    // port logic and pad side
    input  wire psm_pkg::psm_drive_t [PINS-1:0] port_drive,
    input  wire logic [PINS-1:0]                pin_in,
    output logic [PINS-1:0]                     pin_out,
    output logic [PINS-1:0]                     pin_oe,
    // towards the core and the port logic
    output logic [PINS-1:0]                     core_in,
    output logic [PINS-1:0]                     wake_in,
    output logic                                port_reset_mode,
    output logic                                pins_held
);
    import psm_pkg::*;

    // state machine
    psm_state_t               state_ff;
    psm_state_t               nxt_state;

    // pin paths
    psm_drive_t [PINS-1:0]    held_ff;
    logic [PINS-1:0]          core_in_ff;
    logic [PINS-1:0]          nxt_core_in;
    logic [PINS-1:0]          wake_in_ff;
    logic [PINS-1:0]          nxt_wake_in;
    logic [PINS-1:0]          cls_ext;
    logic [PINS-1:0]          cls_nmi;
    logic [PINS-1:0]          cls_can;
    logic [PINS-1:0]          wake_cap;
    logic [PINS-1:0]          live_oe;
    logic [PINS-1:0]          live_out;
    logic [PINS-1:0]          keep_oe;
    logic [PINS-1:0]          keep_out;
    logic [PINS-1:0]          run_oe;
    logic [PINS-1:0]          run_out;

    // decode
    logic                     normal_op;
    logic                     mode_idle;
    logic                     mode_watch;
    logic                     mode_swatch;
    logic                     mode_stop;
    logic                     deep_code;
    logic                     deep_mode;
    logic                     st_reset;
    logic                     st_run;
    logic                     st_hold;
    logic                     go_hold;
    logic                     go_run;
    logic                     capture;
    logic                     holding;

    assign normal_op = (flash_mode_select_pin == PSM_FLASH_NORMAL);
    // deep mode codes decoded one by one; unused codes 6 and 7 never hold
    assign mode_idle   = (power_mode == PSM_IDLE);
    assign mode_watch  = (power_mode == PSM_WATCH);
    assign mode_swatch = (power_mode == PSM_SWATCH);
    assign mode_stop   = (power_mode == PSM_STOP);
    assign deep_code   = mode_idle || mode_watch || mode_swatch || mode_stop;
    // halt is deliberately not a deep mode: pins just follow port logic
    assign deep_mode   = normal_op && deep_code;

    // wake-up capability is fixed per pin at build time, never by software
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_cls
            // any class but none may end a power save state
            assign cls_ext[g]  = (PIN_CLASS[2*g +: 2] == PSM_CLS_EXTI);
            assign cls_nmi[g]  = (PIN_CLASS[2*g +: 2] == PSM_CLS_NMI);
            assign cls_can[g]  = (PIN_CLASS[2*g +: 2] == PSM_CLS_CANR);
            assign wake_cap[g] = cls_ext[g] | cls_nmi[g] |
                                 cls_can[g];
        end
    endgenerate

    assign st_reset = (state_ff == PSM_ST_RESET);
    assign st_run   = (state_ff == PSM_ST_RUN);
    assign st_hold  = (state_ff == PSM_ST_HOLD);
    assign go_hold  = st_run && deep_mode;
    assign go_run   = st_hold && !deep_mode;
    // capture in the same cycle the mode is seen, so outputs never move
    assign capture  = go_hold;
    assign holding  = st_hold || capture;

    always_comb begin
        // stays put unless a transition is due
        nxt_state = state_ff;
        case (state_ff)
            PSM_ST_RESET: begin
                // one cycle in reset state tells port logic to go to input
                nxt_state = PSM_ST_RUN;
            end
            PSM_ST_RUN: begin
                if (go_hold) begin
                    nxt_state = PSM_ST_HOLD;
                end else begin
                    nxt_state = PSM_ST_RUN;
                end
            end
            PSM_ST_HOLD: begin
                if (go_run) begin
                    nxt_state = PSM_ST_RUN;
                end else begin
                    nxt_state = PSM_ST_HOLD;
                end
            end
            default: begin
                nxt_state = PSM_ST_RESET;
            end
        endcase
    end

    // held levels are cleared by reset, so a reset in stop drops them
    psm_hold_reg #(
        .PINS     (PINS)
    ) u_hold (
        .clock    (clock),
        .rstn     (rstn),
        .capture  (capture),
        .drive_in (port_drive),
        .held_ff  (held_ff)
    );

    // reset wins over any power mode
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_ff <= PSM_ST_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // wake-up inputs stay live in every mode
    generate
        for (g = 0; g < PINS; g++) begin : g_wake
            assign nxt_wake_in[g] = pin_in[g] & wake_cap[g];
        end
    endgenerate

    // non-wake inputs frozen while held: no edges reach the core
    generate
        for (g = 0; g < PINS; g++) begin : g_core
            assign nxt_core_in[g] = (holding && !wake_cap[g]) ?
                                    core_in_ff[g] : pin_in[g];
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!rstn) begin
            wake_in_ff <= '0;
        end else begin
            wake_in_ff <= nxt_wake_in;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            core_in_ff <= '0;
        end else begin
            core_in_ff <= nxt_core_in;
        end
    end

    generate
        for (g = 0; g < PINS; g++) begin : g_pad
            assign live_oe[g]  = port_drive[g].oe;
            assign live_out[g] = port_drive[g].out;
            assign keep_oe[g]  = held_ff[g].oe;
            assign keep_out[g] = held_ff[g].out;
        end
    endgenerate

    // port logic is assumed to re-present the same drive on exit,
    // so the switch from held to live value is glitch free; a port
    // change made while held shows up only after exit
    assign run_oe  = st_hold ? keep_oe : live_oe;
    assign run_out = st_hold ? keep_out : live_out;
    // reset state: all pads off; after reset port logic is expected
    // to present inputs (oe low) until software changes it
    assign pin_oe  = st_reset ? {PINS{PSM_OE_RESET}} : run_oe;
    assign pin_out = st_reset ? {PINS{PSM_OUT_RESET}} : run_out;

    assign port_reset_mode = st_reset;
    assign pins_held       = st_hold;
    assign core_in         = core_in_ff;
    assign wake_in         = wake_in_ff;

endmodule : psm_pin_ctrl
`default_nettype wire

// ---- testbench/psm_pin_ctrl_monitor.sv ----
/* checker for psm_pin_ctrl; assumes the bind below onto its ports */
`timescale 1ns/1ps
`default_nettype none
module psm_monitor #(
    parameter int                PINS      = 16,
    parameter logic [2*PINS-1:0] PIN_CLASS = '0
) (
    input wire logic                            clock,
    input wire logic                            rstn,
    input wire logic                            flash_mode_select_pin,
    input wire psm_pkg::psm_mode_t              power_mode,
    input wire psm_pkg::psm_drive_t [PINS-1:0]  port_drive,
    input wire logic [PINS-1:0]                 pin_in,
    input wire logic [PINS-1:0]                 pin_out,
    input wire logic [PINS-1:0]                 pin_oe,
    input wire logic [PINS-1:0]                 core_in,
    input wire logic [PINS-1:0]                 wake_in,
    input wire logic                            port_reset_mode,
    input wire logic                            pins_held
);
    import psm_pkg::*;
    logic [PINS-1:0] d_oe, d_out, wk;
    // codes above stop do not hold, so both ends are bounded
    wire deep = (power_mode >= PSM_IDLE) && (power_mode <= PSM_STOP);
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            d_oe[i] = port_drive[i].oe;
            d_out[i] = port_drive[i].out;
            wk[i] = |PIN_CLASS[2*i+:2];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence enter_s;
        deep && !flash_mode_select_pin && !pins_held && !port_reset_mode;
    endsequence
    reset_hiz_a: assert property (disable iff (1'b0)
        !$past(rstn) |-> !pin_oe && port_reset_mode) else $error("reset drive");
    pins_follow_a: assert property (
        !pins_held && !port_reset_mode |-> pin_oe == d_oe && pin_out == d_out)
        else $error("pins not following port");
    hold_enter_a: assert property (enter_s |=> pins_held)
        else $error("no hold");
    hold_keep_a: assert property (pins_held && $past(pins_held)
        |-> $stable(pin_out) && $stable(pin_oe)) else $error("hold moved");
    hold_exit_a: assert property (
        pins_held && !deep |=> !pins_held) else $error("hold stuck");
    flash_free_a: assert property (
        flash_mode_select_pin && !pins_held |=> !pins_held) else $error("held");
    wake_live_a: assert property (
        !port_reset_mode && $past(rstn) |-> wake_in == ($past(pin_in) & wk))
        else $error("wake input");
    core_freeze_a: assert property (
        pins_held && $past(pins_held) |-> ((core_in ^ $past(core_in)) & ~wk)
        == '0) else $error("input not ignored");
endmodule : psm_monitor
bind psm_pin_ctrl psm_monitor #(.PINS(PINS), .PIN_CLASS(PIN_CLASS)) mon (
    .clock(clock), .rstn(rstn), .flash_mode_select_pin(flash_mode_select_pin),
    .power_mode(power_mode), .port_drive(port_drive), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .core_in(core_in),
    .wake_in(wake_in), .port_reset_mode(port_reset_mode),
    .pins_held(pins_held)
);
`default_nettype wire

// ---- testbench/psm_board.sv ----
/* board side of the pads; assumes the bench sets the board level */
`timescale 1ns/1ps
`default_nettype none
module psm_board (
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    input  wire logic [3:0] board_lvl,
    output logic [3:0]      pad
);
    // a released pad shows the board, never the last driven level
    assign pad = (pin_oe & pin_out) | (~pin_oe & board_lvl);
endmodule : psm_board
`default_nettype wire

// ---- testbench/test_pin_state_power_modes.sv ----
/* bench for psm_pin_ctrl; assumes psm_board closes the pads */
`timescale 1ns/1ps
`default_nettype none
module test_pin_state_power_modes;
    import psm_pkg::*;
    logic             clock, h, port_reset_mode, pins_held;
    logic             rstn = 1'b0;
    logic             flash_mode_select_pin = 1'b0;
    psm_mode_t        power_mode = PSM_RUN;
    psm_drive_t [3:0] port_drive;
    logic [3:0]       pin_in, pin_out, pin_oe, core_in, wake_in;
    logic [3:0]       board_lvl = 4'h0;
    int               error_cnt = 0;
    int               n_tests = 0;
    // {held, flash select, mode}; pin 3 is the only pin without wake-up
    logic [4:0]       rows [6] = '{5'h01, 5'h12, 5'h13, 5'h14, 5'h15, 5'h0d};
    psm_board board (.pin_out(pin_out), .pin_oe(pin_oe),
        .board_lvl(board_lvl), .pad(pin_in));
    psm_pin_ctrl #(.PINS(4), .PIN_CLASS(8'h39)) dut (.clock(clock),
        .rstn(rstn), .flash_mode_select_pin(flash_mode_select_pin),
        .power_mode(power_mode), .port_drive(port_drive), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .core_in(core_in),
        .wake_in(wake_in), .port_reset_mode(port_reset_mode),
        .pins_held(pins_held));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    task automatic chk(input string nm, input logic [3:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic drv(input logic [3:0] oe, out);
        for (int i = 0; i < 4; i++) port_drive[i] = '{oe: oe[i], out: out[i]};
    endtask : drv
    task automatic summarize;
        if (error_cnt == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize
    initial begin
        drv(4'h3, 4'h1);
        cyc(12);
        rstn = 1'b1;
        foreach (rows[r]) begin
            h = rows[r][4];
            drv(4'h3, 4'h1);
            board_lvl = 4'h0;
            power_mode = PSM_RUN;
            flash_mode_select_pin = rows[r][3];
            cyc(3);
            power_mode = psm_mode_t'(rows[r][2:0]);
            cyc(2);
            // port and board both move while the mode is active
            drv(4'h3, 4'h2);
            board_lvl = 4'hf;
            cyc(2);
            chk("pins_held", {3'h0, h}, {3'h0, pins_held});
            chk("pin_out", h ? 4'h1 : 4'h2, pin_out);
            chk("core_in", h ? 4'h5 : 4'he, core_in);
            chk("wake_in", h ? 4'h5 : 4'h6, wake_in);
            power_mode = PSM_RUN;
            cyc(2);
            chk("exit pin_out", 4'h2, pin_out);
            chk("exit core_in", 4'he, core_in);
        end
        // reset arriving in the middle of a held stop
        power_mode = PSM_STOP;
        flash_mode_select_pin = 1'b0;
        cyc(2);
        rstn = 1'b0;
        cyc(2);
        chk("reset pin_oe", 4'h0, pin_oe);
        power_mode = PSM_RUN;
        rstn = 1'b1;
        // still in the reset state until the next edge
        chk("release pin_oe", 4'h0, pin_oe);
        chk("port_reset_mode", 4'h1, {3'h0, port_reset_mode});
        cyc(1);
        chk("port logic back", 4'h0, {3'h0, port_reset_mode});
        cyc(2);
        chk("run pin_oe", 4'h3, pin_oe);
        summarize();
    end
endmodule : test_pin_state_power_modes
`default_nettype wire
